// file: hw/sblp_params.svh
// Notes on behaviour
// R01 - Receive falling edge wakes from stop or sleep.
// R02 - Wake interrupt needs acknowledge and enable both set.
// R03 - Sleep and soft reset keep only register clocks.
// R04 - Power save stops every clock.
// R05 - Mode decoded from CPU state and control bits.
// R06 - CPU wait without stop bit keeps module running.
// R07 - Sleep entry waits for transmit queue and reception.
// R08 - Acknowledge held set throughout sleep.
// R09 - Transmit output recessive while sleeping.
// R10 - Buffers accessible, buffer actions deferred in sleep.
// R11 - Bus activity, request clear or soft reset wake.
// R12 - Request clear ignored until acknowledge reads one.
// R13 - After wake, wait for sync before traffic.
// R14 - Deferred actions executed on wake, buffers kept.
// R15 - Soft reset halts traffic at once.
// R16 - Soft reset halts protocol, registers stay accessible.
// R17 - Soft-reset-only configuration written only in soft reset.
// R18 - Software clears flags without bit set/clear instructions.
// R19 - Master starts sync pulses within transceiver timeout.
// R20 - Software polls acknowledge, avoids arm-then-sleep races.
// R21 - Software sleeps module before CPU stop.
// R22 - Software idles module before soft reset.
// R23 - Host map: control, buffer control, message windows.
// R24 - Acknowledge clears in the same cycle sleep ends; on soft reset the code clears it one cycle after mode leaves sleep.
`ifndef SBLP_PARAMS_SVH
`define SBLP_PARAMS_SVH
`define SBLP_CLK_PERIOD_NS 10
`define SBLP_TSL_MIN_NS 100000
`define SBLP_TSL_MIN_CYC (`SBLP_TSL_MIN_NS / `SBLP_CLK_PERIOD_NS)
`define SBLP_CFG_W 8
`define SBLP_CFG_RST 8'h00
`define SBLP_TX_RECESSIVE 1'b1
`define SBLP_ADDR_W 7
`define SBLP_GEN_BASE 7'h00
`define SBLP_TXB_BASE 7'h20
`define SBLP_RXB_BASE 7'h30
`define SBLP_FIFO_BASE 7'h40
`define SBLP_BCTL_BASE 7'h50
`define SBLP_MAP_END 7'h60
`define SBLP_GEN_SIZE 7'h20
`define SBLP_WIN_SIZE 7'h0E
`define SBLP_NUM_ACT 4
`endif

// file: hw/sblp_pkg.sv
package sblp_pkg;
   typedef enum logic [1:0] {CPU_RUN, CPU_WAIT, CPU_STOP} cpu_state_t;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_SOFT_RESET, MODE_POWER_SAVE} lp_mode_t;
   typedef enum logic [2:0] {REG_GENERAL, REG_TX_BUF, REG_RX_BUF, REG_RX_FIFO, REG_BUF_CTL,
      REG_NONE} region_t;
   typedef struct packed {
      logic soft_reset_request;
      logic sleep_request;
      logic stop_in_cpu_wait;
      logic wakeup_irq_enable;
   } ctl_bits_t;
   // Bit order: abort, lock, unlock, transmit start.
   typedef struct packed {
      logic abort;
      logic lock;
      logic unlock;
      logic tx_start;
   } buf_act_t;
endpackage

// file: hw/rx_falling_edge.sv
`timescale 1ns/100ps
`include "sblp_params.svh"
module rx_falling_edge (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic rx_in,
   output logic fall
);
   logic rx_prev_r;
   logic fall_r;
   wire fall_nxt = rx_prev_r & ~rx_in;
   // The previous sample resets recessive, so a line held low through reset gives one edge just after reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev_r <= `SBLP_TX_RECESSIVE;
         fall_r <= 1'b0;
      end else begin
         rx_prev_r <= rx_in;
         fall_r <= fall_nxt; // [R01]
      end
   end
   assign fall = fall_r;
endmodule

// file: hw/serial_bus_low_power_control.sv
`timescale 1ns/100ps
`include "sblp_params.svh"
module serial_bus_low_power_control #(
   parameter int unsigned TSL_MIN_CYC = `SBLP_TSL_MIN_CYC,
   parameter int unsigned CFG_W = `SBLP_CFG_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sblp_pkg::cpu_state_t cpu_state,
   input wire logic ctl_wr,
   input wire sblp_pkg::ctl_bits_t ctl_wdata,
   input wire logic wake_flag_clr,
   input wire logic cfg_wr,
   input wire logic [CFG_W-1:0] cfg_wdata,
   input wire logic is_bus_master,
   input wire logic tx_pending,
   input wire logic tx_busy,
   input wire logic rx_busy,
   input wire logic rx_in,
   input wire logic tx_data,
   input wire logic sync_pulse_seen,
   input wire sblp_pkg::buf_act_t act_req,
   input wire logic [`SBLP_ADDR_W-1:0] host_addr,
   output sblp_pkg::ctl_bits_t ctl_state,
   output logic sleep_acknowledge,
   output sblp_pkg::lp_mode_t mode,
   output logic core_clk_en,
   output logic reg_clk_en,
   output logic proto_run,
   output logic tx_out,
   output logic wake_irq,
   output sblp_pkg::buf_act_t act_exec,
   output logic [CFG_W-1:0] cfg_q,
   output logic sync_send_req,
   output logic sync_late,
   output sblp_pkg::region_t addr_region
);
   localparam int CNT_W = $clog2(TSL_MIN_CYC + 1);

   // ----------------------------------------
   // Wake edge and mode decode
   // ----------------------------------------
   sblp_pkg::ctl_bits_t ctl_r;
   sblp_pkg::ctl_bits_t ctl_nxt;
   sblp_pkg::lp_mode_t mode_r;
   sblp_pkg::lp_mode_t mode_nxt;
   logic ack_r;
   logic ack_nxt;
   logic rx_fall;

   rx_falling_edge u_edge (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rx_in(rx_in),
      .fall(rx_fall)
   );

   wire idle = ~tx_pending & ~tx_busy & ~rx_busy; // [R07]
   wire enter_sleep = ctl_r.sleep_request & ~ctl_r.soft_reset_request & ~ack_r & idle; // [R07]
   wire bus_wake = ack_r & rx_fall; // [R01]
   wire leave_sleep = ack_r & (rx_fall | ~ctl_r.sleep_request
      | ctl_r.soft_reset_request); // [R11]
   assign ack_nxt = leave_sleep ? 1'b0 : (enter_sleep | ack_r); // [R08] [R24]

   // A clearing write to the request bit is dropped until the acknowledge reads one.
   wire req_clear_ok = ack_r; // [R12]
   wire req_nxt = ctl_wr ? (ctl_wdata.sleep_request | (ctl_r.sleep_request & ~req_clear_ok))
      : (ctl_r.sleep_request & ~bus_wake);
   always_comb begin
      ctl_nxt = ctl_r;
      if (ctl_wr) begin
         ctl_nxt.soft_reset_request = ctl_wdata.soft_reset_request;
         ctl_nxt.stop_in_cpu_wait = ctl_wdata.stop_in_cpu_wait;
         ctl_nxt.wakeup_irq_enable = ctl_wdata.wakeup_irq_enable;
      end
      ctl_nxt.sleep_request = req_nxt;
   end

   wire ps_cond = (cpu_state == sblp_pkg::CPU_STOP)
      | ((cpu_state == sblp_pkg::CPU_WAIT) & ctl_nxt.stop_in_cpu_wait); // [R05] [R06]
   assign mode_nxt = ps_cond ? sblp_pkg::MODE_POWER_SAVE :
      ctl_nxt.soft_reset_request ? sblp_pkg::MODE_SOFT_RESET :
      ack_nxt ? sblp_pkg::MODE_SLEEP : sblp_pkg::MODE_NORMAL; // [R05]

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= '0;
         ack_r <= 1'b0;
         mode_r <= sblp_pkg::MODE_NORMAL;
      end else begin
         ctl_r <= ctl_nxt;
         ack_r <= ack_nxt; // [R08]
         mode_r <= mode_nxt;
      end
   end

   // ----------------------------------------
   // Clocks, protocol run and transmit pin
   // ----------------------------------------
   logic core_clk_en_r;
   logic reg_clk_en_r;
   logic synced_r;
   logic proto_run_r;
   logic tx_out_r;
   wire normal_nxt = (mode_nxt == sblp_pkg::MODE_NORMAL);
   // Synchronisation is lost on every wake and in soft reset; a fresh sync pulse is needed.
   wire synced_nxt = (leave_sleep | ~normal_nxt) ? 1'b0 : (synced_r | sync_pulse_seen); // [R13]
   wire run_nxt = normal_nxt & synced_nxt; // [R13] [R15] [R16]

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         core_clk_en_r <= 1'b0;
         reg_clk_en_r <= 1'b0;
         synced_r <= 1'b0;
         proto_run_r <= 1'b0;
         tx_out_r <= `SBLP_TX_RECESSIVE;
      end else begin
         core_clk_en_r <= normal_nxt; // [R03] [R04]
         reg_clk_en_r <= (mode_nxt != sblp_pkg::MODE_POWER_SAVE); // [R03] [R04]
         synced_r <= synced_nxt;
         proto_run_r <= run_nxt;
         tx_out_r <= run_nxt ? tx_data : `SBLP_TX_RECESSIVE; // [R09] [R15]
      end
   end

   // ----------------------------------------
   // Wake-up interrupt flag
   // ----------------------------------------
   logic wake_flag_r;
   wire wake_set = rx_fall & ack_r & ctl_r.wakeup_irq_enable; // [R02]
   // Set wins over a clear in the same cycle so no wake event is lost.
   wire wake_flag_nxt = wake_set | (wake_flag_r & ~wake_flag_clr);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_flag_r <= 1'b0;
      end else begin
         wake_flag_r <= wake_flag_nxt; // [R02]
      end
   end

   // ----------------------------------------
   // Deferred buffer actions
   // ----------------------------------------
   // Requests made while the protocol clocks are off are held and released on wake.
   logic [`SBLP_NUM_ACT-1:0] pend_r;
   logic [`SBLP_NUM_ACT-1:0] exec_r;
   wire [`SBLP_NUM_ACT-1:0] req_v = act_req;
   wire hold_act = ~normal_nxt; // [R10]
   genvar gi;
   generate
      for (gi = 0; gi < `SBLP_NUM_ACT; gi++) begin : g_act
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               pend_r[gi] <= 1'b0;
               exec_r[gi] <= 1'b0;
            end else begin
               pend_r[gi] <= hold_act & (pend_r[gi] | req_v[gi]); // [R10]
               exec_r[gi] <= ~hold_act & (pend_r[gi] | req_v[gi]); // [R14]
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Soft-reset-only configuration
   // ----------------------------------------
   logic [CFG_W-1:0] cfg_r;
   wire cfg_we = cfg_wr & (mode_r == sblp_pkg::MODE_SOFT_RESET); // [R17]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= CFG_W'(`SBLP_CFG_RST);
      end else if (cfg_we) begin
         cfg_r <= cfg_wdata; // [R16] [R17]
      end
   end

   // ----------------------------------------
   // Master sync start after wake
   // ----------------------------------------
   // The transceiver sleeps again if no sync arrives within its timeout; late is reported.
   logic sync_req_r;
   logic sync_late_r;
   logic [CNT_W-1:0] tsl_cnt_r;
   wire sync_start = leave_sleep & is_bus_master; // [R19]
   wire sync_done = sync_pulse_seen | ~normal_nxt;
   wire cnt_top = (tsl_cnt_r == CNT_W'(TSL_MIN_CYC));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_req_r <= 1'b0;
         sync_late_r <= 1'b0;
         tsl_cnt_r <= '0;
      end else if (sync_start) begin
         sync_req_r <= 1'b1; // [R19]
         sync_late_r <= 1'b0;
         tsl_cnt_r <= '0;
      end else if (sync_req_r & sync_done) begin
         sync_req_r <= 1'b0;
      end else if (sync_req_r & ~cnt_top) begin
         tsl_cnt_r <= tsl_cnt_r + CNT_W'(1);
         sync_late_r <= (tsl_cnt_r == CNT_W'(TSL_MIN_CYC - 1)); // [R19]
      end
   end

   // ----------------------------------------
   // Host map window decode
   // ----------------------------------------
   sblp_pkg::region_t region_r;
   sblp_pkg::region_t region_nxt;
   wire [`SBLP_ADDR_W-1:0] a = host_addr;
   wire in_gen = (a < (`SBLP_GEN_BASE + `SBLP_GEN_SIZE));
   wire in_txb = (a >= `SBLP_TXB_BASE) && (a < (`SBLP_TXB_BASE + `SBLP_WIN_SIZE));
   wire in_rxb = (a >= `SBLP_RXB_BASE) && (a < (`SBLP_RXB_BASE + `SBLP_WIN_SIZE));
   wire in_fifo = (a >= `SBLP_FIFO_BASE) && (a < (`SBLP_FIFO_BASE + `SBLP_WIN_SIZE));
   wire in_bctl = (a >= `SBLP_BCTL_BASE) && (a < `SBLP_MAP_END);
   // Register and buffer windows stay reachable in sleep; only power save loses them.
   wire map_ok = (mode_nxt != sblp_pkg::MODE_POWER_SAVE); // [R10] [R16]
   assign region_nxt = !map_ok ? sblp_pkg::REG_NONE :
      in_gen ? sblp_pkg::REG_GENERAL :
      in_txb ? sblp_pkg::REG_TX_BUF :
      in_rxb ? sblp_pkg::REG_RX_BUF :
      in_fifo ? sblp_pkg::REG_RX_FIFO :
      in_bctl ? sblp_pkg::REG_BUF_CTL : sblp_pkg::REG_NONE; // [R23]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         region_r <= sblp_pkg::REG_NONE;
      end else begin
         region_r <= region_nxt;
      end
   end

   assign ctl_state = ctl_r;
   assign sleep_acknowledge = ack_r;
   assign mode = mode_r;
   assign core_clk_en = core_clk_en_r;
   assign reg_clk_en = reg_clk_en_r;
   assign proto_run = proto_run_r;
   assign tx_out = tx_out_r;
   assign wake_irq = wake_flag_r;
   assign act_exec = exec_r;
   assign cfg_q = cfg_r;
   assign sync_send_req = sync_req_r;
   assign sync_late = sync_late_r;
   assign addr_region = region_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_wake_needs_ack;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(wake_flag_r) |-> $past(ack_r) && $past(ctl_r.wakeup_irq_enable);
   endproperty
   a_wake_needs_ack: assert property (p_wake_needs_ack) else $error("wake irq without ack"); // [R02]

   property p_edge_wakes;
      @(posedge clk_sys) disable iff (!rst_n)
      ack_r && rx_fall |=> !ack_r;
   endproperty
   a_edge_wakes: assert property (p_edge_wakes) else $error("rx edge did not wake"); // [R01]

   property p_sleep_clocks;
      @(posedge clk_sys) disable iff (!rst_n)
      (mode_r == sblp_pkg::MODE_SLEEP || mode_r == sblp_pkg::MODE_SOFT_RESET)
         |-> !core_clk_en_r && reg_clk_en_r;
   endproperty
   a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clock gating wrong"); // [R03]

   property p_ps_clocks;
      @(posedge clk_sys) disable iff (!rst_n)
      mode_r == sblp_pkg::MODE_POWER_SAVE |-> !core_clk_en_r && !reg_clk_en_r;
   endproperty
   a_ps_clocks: assert property (p_ps_clocks) else $error("power save clock running"); // [R04]

   property p_stop_ps;
      @(posedge clk_sys) disable iff (!rst_n)
      cpu_state == sblp_pkg::CPU_STOP |=> mode_r == sblp_pkg::MODE_POWER_SAVE;
   endproperty
   a_stop_ps: assert property (p_stop_ps) else $error("cpu stop not power save"); // [R05]

   property p_enter_busy;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(ack_r) |-> $past(!tx_pending && !tx_busy && !rx_busy);
   endproperty
   a_enter_busy: assert property (p_enter_busy) else $error("sleep entered while busy"); // [R07]

   property p_ack_mode;
      @(posedge clk_sys) disable iff (!rst_n)
      mode_r == sblp_pkg::MODE_SLEEP |-> ack_r;
   endproperty
   a_ack_mode: assert property (p_ack_mode) else $error("sleep without ack"); // [R08] [R24]

   property p_tx_recessive;
      @(posedge clk_sys) disable iff (!rst_n)
      mode_r != sblp_pkg::MODE_NORMAL |-> tx_out_r == `SBLP_TX_RECESSIVE;
   endproperty
   a_tx_recessive: assert property (p_tx_recessive) else $error("tx dominant off normal"); // [R09]

   property p_no_act_sleep;
      @(posedge clk_sys) disable iff (!rst_n)
      mode_r == sblp_pkg::MODE_SLEEP |-> exec_r == '0;
   endproperty
   a_no_act_sleep: assert property (p_no_act_sleep) else $error("action ran in sleep"); // [R10]

   property p_clear_ignored;
      @(posedge clk_sys) disable iff (!rst_n)
      ctl_wr && !ctl_wdata.sleep_request && ctl_r.sleep_request && !ack_r && !bus_wake
         |=> ctl_r.sleep_request;
   endproperty
   a_clear_ignored: assert property (p_clear_ignored) else $error("early request clear"); // [R12]

   property p_wake_unsynced;
      @(posedge clk_sys) disable iff (!rst_n)
      $fell(ack_r) |-> !proto_run_r;
   endproperty
   a_wake_unsynced: assert property (p_wake_unsynced) else $error("ran before sync"); // [R13]

   property p_pending_run;
      @(posedge clk_sys) disable iff (!rst_n)
      (pend_r != '0) && normal_nxt |=> (exec_r & $past(pend_r)) == $past(pend_r);
   endproperty
   a_pending_run: assert property (p_pending_run) else $error("deferred action lost"); // [R14]

   property p_soft_halt;
      @(posedge clk_sys) disable iff (!rst_n)
      ctl_r.soft_reset_request |-> !proto_run_r || $past(!ctl_r.soft_reset_request);
   endproperty
   a_soft_halt: assert property (p_soft_halt) else $error("protocol ran in soft reset"); // [R15] [R16]

   property p_cfg_lock;
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_wr && mode_r != sblp_pkg::MODE_SOFT_RESET |=> $stable(cfg_r);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("config written outside soft reset"); // [R17]

   property p_master_sync;
      @(posedge clk_sys) disable iff (!rst_n)
      sync_start |=> sync_send_req;
   endproperty
   a_master_sync: assert property (p_master_sync) else $error("no sync request on wake"); // [R19]

   c_sleep: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ack_r));
   c_bus_wake: cover property (@(posedge clk_sys) disable iff (!rst_n) bus_wake);
   c_wake_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(wake_flag_r));
   c_soft: cover property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == sblp_pkg::MODE_SOFT_RESET);
endmodule

// file: testbench/sb_bus_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far side of the serial bus
// ----------------------------------------
// The receive line idles recessive, like a pulled-up bus, and goes dominant only for a wake pulse.
module sb_bus_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wake_go,
   input wire logic sync_go,
   output logic rx_in,
   output logic sync_pulse_seen
);
   logic [2:0] low_cnt_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_r <= 3'h0;
         sync_pulse_seen <= 1'b0;
      end else begin
         sync_pulse_seen <= sync_go;
         if (wake_go) begin
            low_cnt_r <= 3'h4;
         end else if (low_cnt_r != 3'h0) begin
            low_cnt_r <= low_cnt_r - 3'h1;
         end
      end
   end
   assign rx_in = (low_cnt_r == 3'h0);
endmodule

// file: testbench/serial_bus_low_power_control_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module serial_bus_low_power_control_tb_top;
   logic clk_sys, rst_n, ctl_wr, wake_flag_clr, cfg_wr, is_bus_master;
   logic tx_pending, tx_busy, rx_busy, rx_in, tx_data, sync_pulse_seen, wake_go, sync_go;
   logic [7:0] cfg_wdata, cfg_q;
   logic [6:0] host_addr;
   sblp_pkg::cpu_state_t cpu_state;
   sblp_pkg::ctl_bits_t ctl_wdata, ctl_state;
   sblp_pkg::buf_act_t act_req, act_exec, last_exec;
   sblp_pkg::lp_mode_t mode, em;
   sblp_pkg::region_t addr_region;
   logic sleep_acknowledge, core_clk_en, reg_clk_en, proto_run, tx_out, wake_irq;
   logic sync_send_req, sync_late;
   int error_cnt = 0;
   int comparisons = 0;
   int exec_cnt = 0;

   serial_bus_low_power_control #(.TSL_MIN_CYC(20), .CFG_W(8)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .cpu_state(cpu_state), .ctl_wr(ctl_wr),
      .ctl_wdata(ctl_wdata), .wake_flag_clr(wake_flag_clr), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .is_bus_master(is_bus_master), .tx_pending(tx_pending),
      .tx_busy(tx_busy), .rx_busy(rx_busy), .rx_in(rx_in), .tx_data(tx_data),
      .sync_pulse_seen(sync_pulse_seen), .act_req(act_req), .host_addr(host_addr),
      .ctl_state(ctl_state), .sleep_acknowledge(sleep_acknowledge), .mode(mode),
      .core_clk_en(core_clk_en), .reg_clk_en(reg_clk_en), .proto_run(proto_run),
      .tx_out(tx_out), .wake_irq(wake_irq), .act_exec(act_exec), .cfg_q(cfg_q),
      .sync_send_req(sync_send_req), .sync_late(sync_late), .addr_region(addr_region));

   sb_bus_model u_bus (.clk_sys(clk_sys), .rst_n(rst_n), .wake_go(wake_go),
      .sync_go(sync_go), .rx_in(rx_in), .sync_pulse_seen(sync_pulse_seen));

   // ----------------------------------------
   // Clock, monitor and helpers
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Action pulses last one cycle, so they are counted here rather than polled.
   always @(posedge clk_sys) begin
      if (act_exec !== 4'h0) begin
         exec_cnt++;
         last_exec = act_exec;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr_ctl(input logic [3:0] v);
      @(posedge clk_sys);
      ctl_wr <= 1'b1;
      ctl_wdata <= v;
      @(posedge clk_sys);
      ctl_wr <= 1'b0;
   endtask

   task automatic pulse_sync();
      @(posedge clk_sys);
      sync_go <= 1'b1;
      @(posedge clk_sys);
      sync_go <= 1'b0;
   endtask

   task automatic wait_ack(input logic v);
      int i;
      i = 0;
      while (sleep_acknowledge !== v && i < 10) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      `CHK("ack", v, sleep_acknowledge)
   endtask

   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_decode();
      logic [6:0] ad [9] = '{7'h00, 7'h1F, 7'h20, 7'h2E, 7'h30, 7'h40, 7'h4E, 7'h50, 7'h60};
      sblp_pkg::region_t rg [9] = '{sblp_pkg::REG_GENERAL, sblp_pkg::REG_GENERAL,
         sblp_pkg::REG_TX_BUF, sblp_pkg::REG_NONE, sblp_pkg::REG_RX_BUF, sblp_pkg::REG_RX_FIFO,
         sblp_pkg::REG_NONE, sblp_pkg::REG_BUF_CTL, sblp_pkg::REG_NONE};
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys);
         host_addr <= ad[i];
         @(posedge clk_sys);
         #1;
         `CHK("region", rg[i], addr_region)
      end
   endtask

   task automatic t_modes();
      for (int c = 0; c < 3; c++) begin
         for (int b = 0; b < 4; b++) begin
            @(posedge clk_sys);
            cpu_state <= sblp_pkg::cpu_state_t'(c[1:0]);
            wr_ctl({b[1], 1'b0, b[0], 1'b0});
            cyc(2);
            #1;
            em = (c == 2 || (c == 1 && b[0])) ? sblp_pkg::MODE_POWER_SAVE :
               b[1] ? sblp_pkg::MODE_SOFT_RESET : sblp_pkg::MODE_NORMAL;
            `CHK("mode", em, mode)
            `CHK("core_clk_en", em == sblp_pkg::MODE_NORMAL, core_clk_en)
            `CHK("reg_clk_en", em != sblp_pkg::MODE_POWER_SAVE, reg_clk_en)
         end
      end
      @(posedge clk_sys);
      cpu_state <= sblp_pkg::CPU_RUN;
      wr_ctl(4'h0);
   endtask

   task automatic t_run_in_wait();
      @(posedge clk_sys);
      cpu_state <= sblp_pkg::CPU_WAIT;
      pulse_sync();
      cyc(1);
      #1;
      `CHK("proto_run", 1'b1, proto_run)
      @(posedge clk_sys);
      tx_data <= 1'b0;
      exec_cnt = 0;
      act_req <= 4'h1;
      @(posedge clk_sys);
      act_req <= 4'h0;
      cyc(1);
      #1;
      `CHK("tx_out", 1'b0, tx_out)
      `CHK("act_exec", 4'h1, last_exec)
      @(posedge clk_sys);
      cpu_state <= sblp_pkg::CPU_RUN;
   endtask

   task automatic t_sleep_cycle();
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         {tx_pending, tx_busy, rx_busy} <= 3'h4 >> i;
         wr_ctl(4'h4);
         cyc(4);
         #1;
         `CHK("ack busy", 1'b0, sleep_acknowledge)
         if (i == 0) begin
            wr_ctl(4'h0);
            #1;
            `CHK("sleep_request", 1'b1, ctl_state.sleep_request)
         end
         @(posedge clk_sys);
         {tx_pending, tx_busy, rx_busy} <= 3'h0;
         wait_ack(1'b1);
         `CHK("mode", sblp_pkg::MODE_SLEEP, mode)
         `CHK("tx_out", 1'b1, tx_out)
         `CHK("core_clk_en", 1'b0, core_clk_en)
         exec_cnt = 0;
         if (i == 2) begin
            @(posedge clk_sys);
            act_req <= 4'hA;
            @(posedge clk_sys);
            act_req <= 4'h0;
            cyc(3);
            `CHK("exec in sleep", 0, exec_cnt)
         end
         wr_ctl(4'h0);
         wait_ack(1'b0);
         `CHK("mode", sblp_pkg::MODE_NORMAL, mode)
         `CHK("wake_irq", 1'b0, wake_irq)
         `CHK("proto_run", 1'b0, proto_run)
         if (i == 2) begin
            cyc(2);
            `CHK("exec count", 1, exec_cnt)
            `CHK("exec", 4'hA, last_exec)
         end
         pulse_sync();
         cyc(1);
         #1;
         `CHK("proto_run", 1'b1, proto_run)
      end
   endtask

   task automatic t_bus_wake();
      @(posedge clk_sys);
      is_bus_master <= 1'b1;
      wr_ctl(4'h5);
      wait_ack(1'b1);
      @(posedge clk_sys);
      cpu_state <= sblp_pkg::CPU_STOP;
      cyc(2);
      #1;
      `CHK("mode stop", sblp_pkg::MODE_POWER_SAVE, mode)
      `CHK("reg_clk_en stop", 1'b0, reg_clk_en)
      `CHK("ack stop", 1'b1, sleep_acknowledge)
      @(posedge clk_sys);
      cpu_state <= sblp_pkg::CPU_RUN;
      @(posedge clk_sys);
      wake_go <= 1'b1;
      @(posedge clk_sys);
      wake_go <= 1'b0;
      wait_ack(1'b0);
      `CHK("wake_irq", 1'b1, wake_irq)
      `CHK("sleep_request", 1'b0, ctl_state.sleep_request)
      `CHK("mode", sblp_pkg::MODE_NORMAL, mode)
      `CHK("sync_send_req", 1'b1, sync_send_req)
      cyc(25);
      `CHK("sync_late", 1'b1, sync_late)
      pulse_sync();
      cyc(2);
      #1;
      `CHK("sync_send_req", 1'b0, sync_send_req)
      `CHK("proto_run", 1'b1, proto_run)
      @(posedge clk_sys);
      wake_flag_clr <= 1'b1;
      @(posedge clk_sys);
      wake_flag_clr <= 1'b0;
      cyc(1);
      #1;
      `CHK("wake_irq", 1'b0, wake_irq)
   endtask

   task automatic t_soft_reset();
      wr_ctl(4'h4);
      wait_ack(1'b1);
      wr_ctl(4'h8);
      cyc(2);
      #1;
      `CHK("mode", sblp_pkg::MODE_SOFT_RESET, mode)
      `CHK("ack soft", 1'b0, sleep_acknowledge)
      `CHK("proto_run", 1'b0, proto_run)
      `CHK("reg_clk_en", 1'b1, reg_clk_en)
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         cfg_wr <= 1'b1;
         cfg_wdata <= k ? 8'h3C : 8'hA5;
         @(posedge clk_sys);
         cfg_wr <= 1'b0;
         cyc(1);
         #1;
         `CHK("cfg_q", 8'hA5, cfg_q)
         wr_ctl(4'h0);
         cyc(2);
      end
   endtask

   // A hang anywhere counts as a failure; the 20000-cycle budget is roughly ninety times the normal run.
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      cpu_state = sblp_pkg::CPU_RUN;
      {ctl_wr, wake_flag_clr, cfg_wr, is_bus_master, wake_go, sync_go} = 6'h00;
      {tx_pending, tx_busy, rx_busy, tx_data} = 4'h1;
      ctl_wdata = 4'h0;
      cfg_wdata = 8'h00;
      act_req = 4'h0;
      host_addr = 7'h00;
      cyc(16);
      rst_n <= 1'b1;
      t_decode();
      t_modes();
      t_run_in_wait();
      t_sleep_cycle();
      t_bus_wake();
      t_soft_reset();
      close_out();
   end
endmodule
